// [pkg/usw_pkg.sv]
// Purpose: Constants for the three-wire serial unit with selectable clocking
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Offsets are byte addresses
package usw_pkg;
    // ========================================================
    // Register map
    localparam logic [7:0] USW_CTRL_OFS = 8'h00;
    localparam logic [7:0] USW_STAT_OFS = 8'h04;
    localparam logic [7:0] USW_DATA_OFS = 8'h08;
    localparam logic [7:0] USW_PORT_OFS = 8'h0C;
    // ========================================================
    // Control fields
    localparam int USW_CTRL_TC = 0;
    localparam int USW_CTRL_CLK = 1;
    localparam int USW_CTRL_CS0 = 2;
    localparam int USW_CTRL_CS1 = 3;
    localparam int USW_CTRL_WM0 = 4;
    localparam int USW_CTRL_WM1 = 5;
    localparam int USW_CTRL_OIE = 6;
    // ========================================================
    // Status fields
    localparam int USW_STAT_CNT_LSB = 0;
    localparam int USW_STAT_OIF = 6;
    // ========================================================
    // Port fields
    localparam int USW_PORT_LATCH = 0;
    localparam int USW_PORT_CDIR = 1;
    localparam int USW_PORT_DDIR = 2;
    localparam int USW_PORT_DLATCH = 3;
    // ========================================================
    // Reset values and mode encodings
    localparam logic [7:0] USW_CTRL_RST = 8'h00;
    localparam logic [7:0] USW_DATA_RST = 8'h00;
    localparam logic [3:0] USW_CNT_RST = 4'h0;
    localparam logic [1:0] USW_WM_THREE = 2'h1;
    localparam logic [1:0] USW_CS_SOFT = 2'h0;
    localparam logic [1:0] USW_CS_TIMER = 2'h1;
endpackage

// [hdl/usw_sync.sv]
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: One core clock
// Notes: Width is a parameter
`timescale 1ns/10ps
module usw_sync #(
    parameter int WIDTH = 2
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end
    assign sync_o = sync_reg;
endmodule // usw_sync

// [hdl/usw_core.sv]
// Purpose: Three-wire serial unit: clock select, shifter, edge counter
// Assumes: APB slave, clock pin sampled by core clock
// Notes: Two-wire modes are not built; wire mode 1x behaves as 00
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/10ps
module usw_core (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic timer_zero_ovf_i,
    input wire logic global_irq_en_i,
    input wire logic serial_in_i,
    input wire logic clock_port_pin_i,
    output logic clock_port_pin_o,
    output logic clock_port_pin_oe_n_o,
    output logic serial_out_o,
    output logic serial_out_oe_n_o,
    output logic overflow_irq_o
);
    import usw_pkg::*;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] shift_data;
        logic [3:0] cnt;
        logic oif;
        logic out_latch;
        logic clk_latch;
        logic clk_dir;
        logic data_dir;
        logic data_latch;
        logic din_prev;
        logic sck_prev;
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic pin_o;
        logic pin_oe_n;
        logic dout;
        logic dout_oe_n;
        logic irq;
    } usw_state_s;

    usw_state_s st_reg;
    usw_state_s st_next;
    logic [1:0] pins_sync;

    // ========================================================
    // Pin synchronisers
    usw_sync #(.WIDTH(2)) u_sync (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .async_i({clock_port_pin_i, serial_in_i}),
        .sync_o(pins_sync)
    );

    // ========================================================
    // Next-state logic
    always_comb begin
        logic wr;
        logic rd;
        logic ext;
        logic edge_sel;
        logic sck;
        logic rise;
        logic fall;
        logic sample_edge;
        logic out_edge;
        logic soft_str;
        logic tog_str;
        logic shift_en;
        logic cnt_en;
        logic [4:0] cnt_sum;
        logic stat_clr;
        logic [7:0] wbyte;
        logic [7:0] ctl;
        wr = 1'b0;
        rd = 1'b0;
        ext = 1'b0;
        edge_sel = 1'b0;
        sck = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        sample_edge = 1'b0;
        out_edge = 1'b0;
        soft_str = 1'b0;
        tog_str = 1'b0;
        shift_en = 1'b0;
        cnt_en = 1'b0;
        cnt_sum = 5'h00;
        stat_clr = 1'b0;
        wbyte = pwdata_i[7:0];
        ctl = 8'h00;
        st_next = st_reg;
        // Writes land on the edge that completes the transfer
        wr = psel_i && penable_i && pwrite_i && st_reg.ready;
        rd = psel_i && penable_i && !pwrite_i && !st_reg.ready;
        // A control write picks its clock source in the same cycle
        ctl = (wr && paddr_i == USW_CTRL_OFS) ? wbyte : st_reg.ctrl;
        ext = ctl[USW_CTRL_CS1];
        edge_sel = ctl[USW_CTRL_CS0];
        sck = pins_sync[1];
        rise = sck && !st_reg.sck_prev;
        fall = !sck && st_reg.sck_prev;
        // sample and shift on one edge, output on the other
        sample_edge = edge_sel ? fall : rise;
        out_edge = edge_sel ? rise : fall;
        soft_str = wr && (paddr_i == USW_CTRL_OFS) && wbyte[USW_CTRL_CLK];
        tog_str = wr && (paddr_i == USW_CTRL_OFS) && wbyte[USW_CTRL_TC];
        if (!ext) begin
            if (ctl[USW_CTRL_CS1:USW_CTRL_CS0] == USW_CS_TIMER) begin
                shift_en = timer_zero_ovf_i;
                cnt_en = timer_zero_ovf_i;
            end else begin
                shift_en = soft_str && (ctl[USW_CTRL_CS1:USW_CTRL_CS0] == USW_CS_SOFT);
                cnt_en = shift_en;
            end
        end else begin
            shift_en = sample_edge;
            if (ctl[USW_CTRL_CLK]) begin
                cnt_en = tog_str;
            end else begin
                cnt_en = rise || fall;
            end
        end
        st_next.sck_prev = sck;
        st_next.din_prev = pins_sync[0];
        // one bit per clock; pin data is already two flops late
        if (shift_en) begin
            st_next.shift_data = {st_reg.shift_data[6:0],
                                  ext ? pins_sync[0] : st_reg.din_prev};
        end
        cnt_sum = {1'b0, st_reg.cnt} + 5'h01;
        if (cnt_en) begin
            st_next.cnt = cnt_sum[3:0];
        end
        if (wr && paddr_i == USW_STAT_OFS) begin
            stat_clr = wbyte[USW_STAT_OIF];
            st_next.cnt = wbyte[USW_STAT_CNT_LSB +: 4];
        end
        if (stat_clr) begin
            st_next.oif = 1'b0;
        end
        if (cnt_en && cnt_sum[4]) begin
            st_next.oif = 1'b1;
        end
        if (wr && paddr_i == USW_DATA_OFS) begin
            st_next.shift_data = wbyte;
        end
        if (wr && paddr_i == USW_CTRL_OFS) begin
            // Strobe bit kept as a select for external mode
            st_next.ctrl = {1'b0, wbyte[6:1], 1'b0};
        end
        if (wr && paddr_i == USW_PORT_OFS) begin
            st_next.clk_latch = wbyte[USW_PORT_LATCH];
            st_next.clk_dir = wbyte[USW_PORT_CDIR];
            st_next.data_dir = wbyte[USW_PORT_DDIR];
            st_next.data_latch = wbyte[USW_PORT_DLATCH];
        end
        if (tog_str) begin
            st_next.clk_latch = !st_reg.clk_latch;
        end
        // external mode: latch output on output edge or on a new transmit byte; other modes follow shift_data bit 7
        if (ext) begin
            if (out_edge || (wr && paddr_i == USW_DATA_OFS)) begin
                st_next.out_latch = st_next.shift_data[7];
            end
        end else begin
            st_next.out_latch = st_next.shift_data[7];
        end
        // APB answer, one wait state
        st_next.ready = (psel_i && penable_i && !st_reg.ready);
        st_next.err = 1'b0;
        if (psel_i && penable_i && !st_reg.ready) begin
            st_next.err = !(paddr_i == USW_CTRL_OFS || paddr_i == USW_STAT_OFS ||
                            paddr_i == USW_DATA_OFS || paddr_i == USW_PORT_OFS);
        end
        if (rd) begin
            case (paddr_i)
                USW_CTRL_OFS: st_next.rdata = {24'h000000, st_reg.ctrl[7:2], 2'b00};
                USW_STAT_OFS: st_next.rdata = {25'h0000000, st_reg.oif, 2'b00, st_reg.cnt};
                USW_DATA_OFS: st_next.rdata = {24'h000000, st_reg.shift_data};
                USW_PORT_OFS: st_next.rdata = {28'h0000000, st_reg.data_latch,
                                               st_reg.data_dir, st_reg.clk_dir,
                                               st_reg.clk_latch};
                default: st_next.rdata = 32'h00000000;
            endcase
        end
        if (st_reg.ctrl[5:4] == USW_WM_THREE) begin
            st_next.dout = st_next.out_latch;
        end else begin
            st_next.dout = st_next.data_latch;
        end
        st_next.dout_oe_n = !st_next.data_dir;
        st_next.pin_o = st_next.clk_latch;
        st_next.pin_oe_n = !st_next.clk_dir;
        st_next.irq = st_next.oif && st_next.ctrl[USW_CTRL_OIE] && global_irq_en_i;
    end

    // ========================================================
    // State register
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            st_reg <= '{pin_oe_n: 1'b1, dout_oe_n: 1'b1, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata_o = st_reg.rdata;
    assign pready_o = st_reg.ready;
    assign pslverr_o = st_reg.err;
    assign clock_port_pin_o = st_reg.pin_o;
    assign clock_port_pin_oe_n_o = st_reg.pin_oe_n;
    assign serial_out_o = st_reg.dout;
    assign serial_out_oe_n_o = st_reg.dout_oe_n;
    assign overflow_irq_o = st_reg.irq;

    // ========================================================
    // Checks
    sw_strobe_shift_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (psel_i && penable_i && pwrite_i && pready_o && paddr_i == USW_CTRL_OFS
         && pwdata_i[3:1] == 3'b001)
        |=> (st_reg.cnt == $past(st_reg.cnt) + 4'h1 || $past(st_reg.cnt) == 4'hF))
        else $error("strobe did not count");
    strobe_read_zero_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (pready_o && psel_i && !pwrite_i && paddr_i == USW_CTRL_OFS)
        |-> prdata_o[1:0] == 2'b00) else $error("strobe bits read back");
    toggle_latch_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (psel_i && penable_i && pwrite_i && pready_o && paddr_i == USW_CTRL_OFS
         && pwdata_i[0]) |=> (st_reg.clk_latch != $past(st_reg.clk_latch)))
        else $error("toggle failed");
    pin_dir_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        clock_port_pin_oe_n_o == !st_reg.clk_dir) else $error("clock pin enable wrong");
    ovf_flag_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (st_reg.cnt == 4'hF && !(psel_i && penable_i && pwrite_i && paddr_i == USW_STAT_OFS))
        ##1 (st_reg.cnt == 4'h0) |-> st_reg.oif)
        else $error("overflow flag missing");
    flag_sticky_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (st_reg.oif && !(psel_i && penable_i && pwrite_i && paddr_i == USW_STAT_OFS))
        |=> st_reg.oif) else $error("flag lost");
    irq_gate_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        overflow_irq_o |-> st_reg.oif && st_reg.ctrl[USW_CTRL_OIE] && $past(global_irq_en_i))
        else $error("irq without flag");
    transparent_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !st_reg.ctrl[USW_CTRL_CS1] |-> st_reg.out_latch == st_reg.shift_data[7])
        else $error("latch not transparent");
    apb_ready_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (psel_i && penable_i && !pready_o) |=> pready_o) else $error("no answer");
    ovf_cov: cover property (@(posedge core_clk_i) disable iff (rst_i) $rose(st_reg.oif));
    ext_cov: cover property (@(posedge core_clk_i) disable iff (rst_i)
        st_reg.ctrl[USW_CTRL_CS1] && st_reg.cnt == 4'h8);
    irq_cov: cover property (@(posedge core_clk_i) disable iff (rst_i) overflow_irq_o);
endmodule // usw_core

// [testbench/usw_spi_peer.sv]
// Purpose: Far-side SPI master or slave model for the serial link
// Assumes: Link clock period of 160 ns, idle low, made only within frames
// Notes: Driven through its tasks; data line not held after a frame
`timescale 1ns/10ps
module usw_spi_peer (
    output logic sck_o,
    output logic mosi_o,
    input wire logic miso_i
);
    initial begin
        sck_o = 1'b0;
        mosi_o = 1'b0;
    end
    // ========================================================
    // Master transfer, MSB first
    // data set early in mode 0, on the rising edge in mode 1; two toggles per bit
    task automatic xfer(input logic mode, input logic [7:0] tx, output logic [7:0] rx);
        #3;
        if (!mode) mosi_o = tx[7];
        #80;
        for (int i = 7; i >= 0; i--) begin
            sck_o = 1'b1;
            if (mode) mosi_o = tx[i];
            else rx[i] = miso_i;
            #80;
            sck_o = 1'b0;
            if (mode) rx[i] = miso_i;
            else if (i > 0) mosi_o = tx[i-1];
            #80;
        end
        // released line, not the last value
        mosi_o = ~mosi_o;
    endtask
    // Slave presents one bit
    task automatic put(input logic b);
        mosi_o = b;
    endtask
endmodule // usw_spi_peer

// [testbench/usw_core_tb.sv]
// Purpose: Self-checking bench for the three-wire serial unit
// Assumes: APB master in this bench, SPI peer model on the link
// Notes: Seeded random data with fixed corner cases
`timescale 1ns/10ps
module usw_core_tb;
    import usw_pkg::*;
    logic clk, rst, psel, penable, pwrite, tovf, gie, pready, pslverr, err, m;
    logic sck, mosi, miso, ck_o, ck_oe_n, so, so_oe_n, irq;
    logic [7:0] paddr, tx, rx, d, sh;
    logic [31:0] pwdata, prdata, q;
    int mismatches, n_tests, cyc, p;
    usw_core u_usw_core (.core_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .timer_zero_ovf_i(tovf),
        .global_irq_en_i(gie), .serial_in_i(mosi), .clock_port_pin_i(sck),
        .clock_port_pin_o(ck_o), .clock_port_pin_oe_n_o(ck_oe_n), .serial_out_o(so),
        .serial_out_oe_n_o(so_oe_n), .overflow_irq_o(irq));
    usw_spi_peer u_usw_spi_peer (.sck_o(sck), .mosi_o(mosi), .miso_i(miso));
    // Undriven data line shows the inverse, not a held value
    assign miso = so_oe_n ? ~so : so;
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ========================================================
    // Helpers
    function automatic logic [7:0] st(input logic f, input logic [3:0] c);
        return {1'b0, f, 2'b00, c};
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task wr(input logic [7:0] a, input logic [7:0] v);
        apb(1'b1, a, {24'h0, v});
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0);
        chk(q, {24'h0, e});
    endtask
    task results;
        $display("mismatches %0d n_tests %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            results;
        end
    end
    // ========================================================
    // Scenarios
    initial begin
        void'($urandom(24));
        {psel, penable, pwrite, tovf, gie, rst} = 6'h01;
        paddr = 8'h00;
        pwdata = 32'h0;
        {mismatches, n_tests, cyc} = '0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(32'({ck_oe_n, so_oe_n}), 32'h3);
        for (int i = 0; i < 4; i++) rd(8'(i * 4), 8'h00);
        apb(1'b0, 8'h10, 32'h0);
        chk({q[30:0], err}, 32'h1);
        wr(USW_PORT_OFS, 8'h06);
        chk(32'({ck_oe_n, so_oe_n}), 32'h0);
        wr(USW_CTRL_OFS, 8'h01);
        chk(32'(ck_o), 32'h1);
        rd(USW_CTRL_OFS, 8'h00);
        wr(USW_PORT_OFS, 8'h04);
        wr(USW_CTRL_OFS, 8'h01);
        rd(USW_PORT_OFS, 8'h05);
        chk(32'(ck_oe_n), 32'h1);
        wr(USW_PORT_OFS, 8'h06);
        gie <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            m = k[0];
            d = (k == 2) ? 8'hFF : 8'($urandom);
            tx = (k == 2) ? 8'h00 : 8'($urandom);
            wr(USW_DATA_OFS, d);
            wr(USW_STAT_OFS, 8'h40);
            wr(USW_CTRL_OFS, {1'b0, m, 3'b011, m, 2'b00});
            u_usw_spi_peer.xfer(m, tx, rx);
            repeat (8) @(posedge clk);
            rd(USW_STAT_OFS, st(1'b1, 4'h0));
            chk(32'(irq), 32'(m));
            rd(USW_DATA_OFS, tx);
            chk(32'(rx), 32'(d));
            wr(USW_STAT_OFS, 8'h43);
            rd(USW_STAT_OFS, st(1'b0, 4'h3));
            chk(32'(irq), 32'h0);
        end
        d = 8'($urandom);
        tx = 8'($urandom);
        sh = d;
        wr(USW_DATA_OFS, d);
        wr(USW_STAT_OFS, 8'h40);
        for (int i = 7; i >= 0; i--) begin
            u_usw_spi_peer.put(tx[i]);
            repeat (4) @(posedge clk);
            wr(USW_CTRL_OFS, 8'h12);
            sh = {sh[6:0], tx[i]};
            chk(32'(so), 32'(sh[7]));
        end
        rd(USW_STAT_OFS, st(1'b0, 4'h8));
        rd(USW_DATA_OFS, tx);
        rd(USW_CTRL_OFS, 8'h10);
        p = 1 + $urandom % 15;
        wr(USW_STAT_OFS, 8'h40);
        for (int j = 0; j < 2; j++) begin
            wr(USW_CTRL_OFS, j ? 8'h10 : 8'h16);
            repeat (p) begin
                tovf <= 1'b1;
                @(posedge clk);
                tovf <= 1'b0;
                @(posedge clk);
            end
            rd(USW_STAT_OFS, st(1'b0, 4'(p)));
        end
        wr(USW_STAT_OFS, 8'h40);
        repeat (16) wr(USW_CTRL_OFS, 8'h1B);
        rd(USW_STAT_OFS, st(1'b1, 4'h0));
        chk(32'({ck_o, irq}), 32'h0);
        wr(USW_CTRL_OFS, 8'h58);
        chk(32'(irq), 32'h1);
        results;
    end
endmodule // usw_core_tb
